// ===== logic/stc_timer.v
// Sixteen-bit timer/counter with prescaler, overflow interrupt, AHB-Lite slave
//
// Overview of operation
// - Prescale code divides input by 1,2,4,8
// - Source select: instruction clock or pin edges
// - External input synchronised unless sync disabled
// - Internal source ignores the sync control bit
// - Oscillator enable runs or stops timer oscillator
// - Timer on enables counting; off holds count
// - Read-only status: sysclk derived from timer osc
// - Count bytes readable and writable by software
// - CPU interrupt needs enable, global and peripheral gates
// - Power-on reset clears control; top bit reads 0
//
// Limitations: the count is two byte registers with no latch, so
// reading low then high while running may tear. The count bytes
// power up unknown; software writes them before first use.
`timescale 1ns/10ps
`include "stc_map.vh"

module stc_timer (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        por_n,
  input  wire        clk_en,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        ext_clock_pin,
  input  wire        sysclk_from_timer_osc,
  output reg         osc_out_pin,
  output reg         osc_run,
  output reg         irq,
  output reg         cpu_irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [6:0]  tctl_q;
  reg [1:0]  intctl_q;
  reg        ovf_flag_q;
  reg        ovf_ie_q;
  reg [15:0] count_value_q;
  reg [15:0] count_value_d;
  reg        evstat_q;
  reg        evmask_q;
  reg [2:0]  pin_sync_q;
  reg        pin_last_q;
  reg        async_last_q;
  reg [1:0]  div_q;
  reg [2:0]  pre_q;
  reg        run_sync_q;
  reg        run_meta_q;
  reg        run_mid_q;
  reg        run_late_q;
  reg        wr_pend_q;
  reg        rd_pend_q;
  reg [7:0]  idx_q;

  wire       timer_on            = tctl_q[`STC_ON_BIT];
  wire       clock_source_select = tctl_q[`STC_CS_BIT];
  wire       ext_sync_disable    = tctl_q[`STC_NSYNC_BIT];
  wire       timer_osc_enable    = tctl_q[`STC_OSCEN_BIT];
  wire [1:0] prescale_select     = tctl_q[`STC_CKPS_HI:`STC_CKPS_LO];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire       acc   = hsel && hready && htrans[1];
  wire [7:0] a_idx = haddr[9:2];
  wire       wr    = wr_pend_q;
  wire [7:0] wd    = hwdata[7:0];

  // Write strobes, one per writable register, taken at end of data phase
  wire       wr_intctl  = wr && (idx_q == `STC_IDX_INTCTL);
  wire       wr_pflags  = wr && (idx_q == `STC_IDX_PFLAGS);
  wire       wr_cntlo   = wr && (idx_q == `STC_IDX_CNTLO);
  wire       wr_cnthi   = wr && (idx_q == `STC_IDX_CNTHI);
  wire       wr_tctl    = wr && (idx_q == `STC_IDX_TCTL);
  wire       wr_penable = wr && (idx_q == `STC_IDX_PENABLE);
  wire       wr_evmask  = wr && (idx_q == `STC_IDX_EVMASK);

  // ----------------------------------------------------------------
  // Count input edge selection
  // ----------------------------------------------------------------
  // Synchronised pin: act once stages two and three agree
  wire pin_sync_rise = pin_sync_q[2] & pin_sync_q[1] & ~pin_last_q;
  // Unsynchronised mode still samples pin here, one flop shorter
  wire pin_async_rise = pin_sync_q[1] & ~async_last_q;
  wire instr_tick = (div_q == `STC_INSTR_DIV);
  reg  src_tick;
  reg  pre_tick;

  always @* begin
    if (!clock_source_select)
      src_tick = instr_tick;
    else if (ext_sync_disable)
      src_tick = pin_async_rise;
    else
      src_tick = pin_sync_rise;
  end

  always @* begin
    case (prescale_select)
      2'h0: pre_tick = src_tick;
      2'h1: pre_tick = src_tick & (pre_q[0] == 1'b1);
      2'h2: pre_tick = src_tick & (pre_q[1:0] == 2'h3);
      2'h3: pre_tick = src_tick & (pre_q == 3'h7);
      default: pre_tick = src_tick;
    endcase
  end

  wire count_tick = timer_on & pre_tick;
  wire overflow   = count_tick & (count_value_q == 16'hffff);
  wire rd_evstat  = rd_pend_q & (idx_q == `STC_IDX_EVSTAT);

  always @* begin
    count_value_d = count_value_q;
    if (count_tick)
      count_value_d = count_value_q + 16'h0001;
    // A software preload wins over a tick in the same cycle
    if (wr_cntlo)
      count_value_d[7:0] = wd;
    if (wr_cnthi)
      count_value_d[15:8] = wd;
  end

  // ----------------------------------------------------------------
  // Counter and clock path
  // ----------------------------------------------------------------
  // Count bytes are never reset: state survives every reset kind
  always @(posedge clock) begin
    if (clk_en) begin
      count_value_q <= count_value_d;
      pin_sync_q    <= {pin_sync_q[1:0], ext_clock_pin};
      pin_last_q    <= pin_sync_q[2] & pin_sync_q[1];
      async_last_q  <= pin_sync_q[1];
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      div_q <= 2'h0;
      pre_q <= 3'h0;
    end else if (clk_en) begin
      div_q <= div_q + 2'h1;
      // Cleared while off so a restart begins a full prescale period
      if (!timer_on)
        pre_q <= 3'h0;
      else if (src_tick)
        pre_q <= pre_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers, power-on domain
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!por_n) begin
      tctl_q <= `STC_TCTL_RST;
    end else if (clk_en && wr_tctl) begin
      tctl_q <= {1'b0, wd[5:0]};
    end
  end


  // ----------------------------------------------------------------
  // Interrupt registers, plain reset domain
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_n) begin
      intctl_q <= `STC_INTCTL_RST;
    end else if (clk_en && wr_intctl) begin
      intctl_q <= wd[`STC_GIE_BIT:`STC_PERIPHERAL_IRQ_GATE_BIT];
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      ovf_ie_q <= `STC_PEN_RST;
    end else if (clk_en && wr_penable) begin
      ovf_ie_q <= wd[`STC_OVF_BIT];
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      evmask_q <= 1'b0;
    end else if (clk_en && wr_evmask) begin
      evmask_q <= wd[0];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always @(posedge clock) begin
    if (!rst_n) begin
      ovf_flag_q <= `STC_PFLAG_RST;
    end else if (clk_en) begin
      if (overflow)
        ovf_flag_q <= 1'b1;
      else if (wr_pflags)
        ovf_flag_q <= wd[`STC_OVF_BIT];
    end
  end

  // Sticky copy of overflow; reading it clears, a new event wins
  always @(posedge clock) begin
    if (!rst_n) begin
      evstat_q <= 1'b0;
    end else if (clk_en) begin
      if (overflow)
        evstat_q <= 1'b1;
      else if (rd_evstat)
        evstat_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: one wait-free data phase, always OKAY
  // ----------------------------------------------------------------
  // Read data is latched in the address phase, so a read right
  // after a write to the same register returns the old value
  reg [7:0] rd_byte;
  always @* begin
    case (a_idx)
      `STC_IDX_INTCTL:  rd_byte = {intctl_q, 6'h00};
      `STC_IDX_PFLAGS:  rd_byte = {7'h00, ovf_flag_q};
      `STC_IDX_CNTLO:   rd_byte = count_value_q[7:0];
      `STC_IDX_CNTHI:   rd_byte = count_value_q[15:8];
      `STC_IDX_TCTL:    rd_byte = {1'b0, run_sync_q, tctl_q[5:0]};
      `STC_IDX_PENABLE: rd_byte = {7'h00, ovf_ie_q};
      `STC_IDX_EVSTAT:  rd_byte = {7'h00, evstat_q};
      `STC_IDX_EVMASK:  rd_byte = {7'h00, evmask_q};
      default:          rd_byte = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      wr_pend_q <= acc & hwrite;
      rd_pend_q <= acc & ~hwrite;
      if (acc) begin
        idx_q <= a_idx;
        if (!hwrite)
          hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Status crossing and oscillator outputs
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_n) begin
      run_meta_q  <= 1'b0;
      run_mid_q   <= 1'b0;
      run_late_q  <= 1'b0;
      run_sync_q  <= 1'b0;
      osc_run     <= 1'b0;
      osc_out_pin <= 1'b0;
    end else if (clk_en) begin
      run_meta_q  <= sysclk_from_timer_osc;
      run_mid_q   <= run_meta_q;
      run_late_q  <= run_mid_q;
      // Status changes only once stages two and three agree
      if (run_mid_q == run_late_q)
        run_sync_q <= run_late_q;
      osc_run     <= timer_osc_enable;
      // Inverter off when disabled so the pin draws no drive current
      osc_out_pin <= timer_osc_enable & ~pin_sync_q[2];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_n) begin
      irq     <= 1'b0;
      cpu_irq <= 1'b0;
    end else if (clk_en) begin
      irq     <= (evstat_q | overflow) & evmask_q;
      cpu_irq <= ovf_flag_q & ovf_ie_q & (&intctl_q);
    end
  end

endmodule

// ===== inc/stc_map.vh
// Register map, field positions and reset values of the 16-bit timer
`ifndef STC_MAP_VH
`define STC_MAP_VH

`define STC_IDX_INTCTL     8'h0b
`define STC_IDX_PFLAGS     8'h0c
`define STC_IDX_CNTLO      8'h0e
`define STC_IDX_CNTHI      8'h0f
`define STC_IDX_TCTL       8'h10
`define STC_IDX_PENABLE    8'h8c
`define STC_IDX_EVSTAT     8'h90
`define STC_IDX_EVMASK     8'h91
`define STC_IDX_SYSCTL     8'h92

`define STC_GIE_BIT        7
`define STC_PERIPHERAL_IRQ_GATE_BIT       6
`define STC_OVF_BIT        0
`define STC_RUN_BIT        6
`define STC_CKPS_HI        5
`define STC_CKPS_LO        4
`define STC_OSCEN_BIT      3
`define STC_NSYNC_BIT      2
`define STC_CS_BIT         1
`define STC_ON_BIT         0

`define STC_TCTL_RST       7'h00
`define STC_INTCTL_RST     2'h0
`define STC_PFLAG_RST      1'h0
`define STC_PEN_RST        1'h0
`define STC_CNT_RST        16'h0000
`define STC_INSTR_DIV      2'h3

`endif

// ===== bench/stc_timer_sva.sv
// Checker of the timer bus and interrupt outputs
`timescale 1ns/10ps
`include "stc_map.vh"
module stc_timer_sva (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        osc_out_pin,
  input wire logic        osc_run,
  input wire logic        irq,
  input wire logic        cpu_irq
);
  // ----
  // Bus and output relations
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_acc(logic w, logic [7:0] i);
    hsel && hready && htrans[1] && hwrite == w && haddr == {22'h0, i, 2'h0};
  endsequence
  AST_READY: assert property (hreadyout) else $error("wait state");
  AST_OKAY: assert property (!hresp) else $error("bad response");
  AST_TOP0: assert property (
    s_acc(1'b0, `STC_IDX_TCTL) |=> hrdata[31:7] == 25'h0)
    else $error("control top bits set");
  AST_OSC_ON: assert property (
    s_acc(1'b1, `STC_IDX_TCTL) ##1 hwdata[3] |-> ##[1:3] osc_run)
    else $error("oscillator not started");
  AST_OSC_OFF: assert property (
    s_acc(1'b1, `STC_IDX_TCTL) ##1 !hwdata[3] |-> ##[1:3] !osc_run)
    else $error("oscillator not stopped");
  AST_OSC_QUIET: assert property (
    !osc_run && !$past(osc_run) |-> !osc_out_pin)
    else $error("idle oscillator toggles");
  AST_CPU_GATE: assert property (
    s_acc(1'b1, `STC_IDX_INTCTL) ##1 hwdata[7:6] != 2'h3
    |-> ##[1:3] !cpu_irq) else $error("interrupt not gated");
  AST_IRQ_CLR: assert property (
    s_acc(1'b0, `STC_IDX_EVSTAT) |-> ##[1:3] !irq)
    else $error("status not cleared by read");
endmodule
bind stc_timer stc_timer_sva u_sva (.clock, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .osc_out_pin,
  .osc_run, .irq, .cpu_irq);

// ===== bench/stc_ext_src.sv
// Model of an external count clock feeding the timer pin
`timescale 1ns/10ps
module stc_ext_src (
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [2:0] half,
  output logic            pin
);
  logic [2:0] n_q = 3'h0;
  initial pin = 1'b0;
  // Stands low between bursts, never free-running
  always @(posedge clock) begin
    if (!run) begin
      pin <= 1'b0;
      n_q <= 3'h0;
    end else if (n_q == half - 3'h1) begin
      pin <= ~pin;
      n_q <= 3'h0;
    end else begin
      n_q <= n_q + 3'h1;
    end
  end
endmodule

// ===== bench/stc_timer_tb.sv
// Self-checking bench of the 16-bit timer over its register bus
`timescale 1ns/10ps
`include "stc_map.vh"
module stc_timer_tb;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        por_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        run = 1'b0;
  logic        clk_en = 1'b1;
  logic        sysclk_from_timer_osc = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  half = 3'h4;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] q;
  logic [31:0] a;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, ext_clock_pin, osc_out_pin;
  wire         osc_run, irq, cpu_irq;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  stc_ext_src u_src (.clock, .run, .half, .pin(ext_clock_pin));
  stc_timer u_dut (.clock, .rst_n, .por_n, .clk_en, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .ext_clock_pin, .sysclk_from_timer_osc,
    .osc_out_pin, .osc_run, .irq, .cpu_irq);
  always #2 clock = ~clock;
  // ----
  // Bus access and checking
  // ----
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, i, 2'h0};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0);
    chk(q, e);
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge clock);
    rdc(`STC_IDX_TCTL, 32'h0);
    rdc(`STC_IDX_PFLAGS, 32'h0);
    rdc(`STC_IDX_PENABLE, 32'h0);
    xfer(1'b1, 8'h20, 32'hff);
    rdc(8'h20, 32'h0);
    $display("test reset done");
    xfer(1'b1, `STC_IDX_CNTLO, 32'h5a);
    xfer(1'b1, `STC_IDX_CNTHI, 32'ha5);
    xfer(1'b1, `STC_IDX_TCTL, 32'h3c);
    sysclk_from_timer_osc <= 1'b1;
    // Plain reset only: control and count must survive it
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rdc(`STC_IDX_TCTL, 32'h7c);
    rdc(`STC_IDX_CNTLO, 32'h5a);
    rdc(`STC_IDX_CNTHI, 32'ha5);
    chk({31'h0, osc_run}, 32'h1);
    sysclk_from_timer_osc <= 1'b0;
    xfer(1'b1, `STC_IDX_TCTL, 32'h0);
    repeat (4) @(posedge clock);
    rdc(`STC_IDX_TCTL, 32'h0);
    chk({30'h0, osc_run, osc_out_pin}, 32'h0);
    $display("test control done");
    // Sync-disable set with internal source must not matter
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, `STC_IDX_CNTLO, 32'h0);
      xfer(1'b1, `STC_IDX_CNTHI, 32'h0);
      xfer(1'b1, `STC_IDX_TCTL, 32'h5 | (c << 4));
      repeat (64) @(posedge clock);
      xfer(1'b1, `STC_IDX_TCTL, 32'h0);
      xfer(1'b0, `STC_IDX_CNTLO, 32'h0);
      a = q;
      chk({31'h0, q + 1 - (16 >> c) < 3}, 32'h1);
      repeat (8) @(posedge clock);
      rdc(`STC_IDX_CNTLO, a);
    end
    for (int s = 0; s < 2; s++) begin
      xfer(1'b1, `STC_IDX_CNTLO, 32'h0);
      xfer(1'b1, `STC_IDX_TCTL, 32'h3 | (s << 2));
      half <= s ? 3'h2 : 3'h4;
      run <= 1'b1;
      repeat (80) @(posedge clock);
      run <= 1'b0;
      repeat (8) @(posedge clock);
      rdc(`STC_IDX_CNTLO, s ? 32'd20 : 32'd10);
    end
    // Clock enable low must freeze the running count
    xfer(1'b1, `STC_IDX_CNTLO, 32'h0);
    xfer(1'b1, `STC_IDX_TCTL, 32'h1);
    clk_en <= 1'b0;
    repeat (40) @(posedge clock);
    clk_en <= 1'b1;
    xfer(1'b1, `STC_IDX_TCTL, 32'h0);
    xfer(1'b0, `STC_IDX_CNTLO, 32'h0);
    chk({31'h0, q < 32'h2}, 32'h1);
    $display("test counting done");
    xfer(1'b1, `STC_IDX_CNTLO, 32'hfe);
    xfer(1'b1, `STC_IDX_CNTHI, 32'hff);
    xfer(1'b1, `STC_IDX_TCTL, 32'h1);
    repeat (16) @(posedge clock);
    xfer(1'b1, `STC_IDX_TCTL, 32'h0);
    rdc(`STC_IDX_CNTHI, 32'h0);
    rdc(`STC_IDX_PFLAGS, 32'h1);
    xfer(1'b1, `STC_IDX_PENABLE, 32'h1);
    xfer(1'b1, `STC_IDX_INTCTL, 32'h80);
    repeat (3) @(posedge clock);
    chk({31'h0, cpu_irq}, 32'h0);
    xfer(1'b1, `STC_IDX_INTCTL, 32'hc0);
    repeat (3) @(posedge clock);
    chk({31'h0, cpu_irq}, 32'h1);
    rdc(`STC_IDX_PFLAGS, 32'h1);
    xfer(1'b1, `STC_IDX_PFLAGS, 32'h0);
    repeat (3) @(posedge clock);
    chk({31'h0, cpu_irq}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `STC_IDX_EVMASK, 32'h1);
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    rdc(`STC_IDX_EVSTAT, 32'h1);
    repeat (3) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("test overflow done");
    end_of_test();
  end
endmodule
